// ### rtl/bsc_pkg.sv
// shared constants and types of the battery sensor system control block
package bsc_pkg;
    // address map
    localparam logic [31:0] SRAM_BASE = 32'h0004_0000;
    localparam logic [31:0] FLASH_BASE = 32'h0008_0000;
    localparam logic [31:0] MMR_BASE = 32'hFFFF_0000;
    localparam logic [31:0] ZERO_SEL_ADDR = 32'hFFFF_0220;
    localparam logic [31:0] CAUSE_STAT_ADDR = 32'hFFFF_0230;
    localparam logic [31:0] CAUSE_CLR_ADDR = 32'hFFFF_0234;
    localparam logic [31:0] VECTOR_TOP = 32'h0000_0020;
    // field positions
    localparam int REMAP_BIT = 0;
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_WDT = 1;
    localparam int CAUSE_SOFT = 2;
    localparam int CAUSE_PIN = 3;
    // values after reset
    localparam logic REMAP_RST = 1'b0;
    localparam logic [3:0] CAUSE_RST = 4'h1;
    // access sizes on the core bus
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    // exception vectors
    localparam logic [4:0] VEC_FAST = 5'h1C;
    localparam logic [4:0] VEC_NORM = 5'h18;
    // timing
    localparam int IRQ_STAGES = 5;
    localparam int CLK_NS = 10;
    localparam int RESET_HOLD_NS = 160;
    localparam logic [7:0] RESET_HOLD_CYC = 8'((RESET_HOLD_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [2:0] {RG_NONE, RG_SRAM, RG_FLASH, RG_MMR, RG_SYS} bsc_region_t;
    typedef enum logic [1:0] {RS_HOLD, RS_KERNEL, RS_RUN} bsc_rstate_t;
endpackage : bsc_pkg

// ### rtl/bsc_sram.sv
// word-organised sram with byte lanes, flip-flop storage
`timescale 1ns/1ns
module bsc_sram #(
    parameter int WORDS = 1024
) (
    // clock
    input wire logic mclk,
    // access
    input wire logic en,
    input wire logic wr,
    input wire logic [3:0] be,
    input wire logic [$clog2(WORDS)-1:0] idx,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata
);
    // a single word leaves no index bits to address it
    if (WORDS < 2) begin : g_bad_words
        $error("bsc_sram: at least two words needed");
    end

    typedef struct packed {
        logic [WORDS-1:0][31:0] mem;
    } bsc_sram_t;

    bsc_sram_t st;
    bsc_sram_t next_st;

    // lane 0 is the lowest byte address: little endian
    always_comb begin
        next_st = st;
        for (int b = 0; b < 4; b++) begin
            if (en && wr && be[b]) begin
                next_st.mem[idx][b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
    end

    // no reset: contents survive every reset except loss of supply
    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign rdata = st.mem[idx];
endmodule : bsc_sram

// ### rtl/bsc_sysctl.sv
// address decode, remap, reset cause and interrupt entry timing
`timescale 1ns/1ns
// Functional notes
// R1 - interrupt reaches exception entry after five cycles
// R2 - handler starts in 32-bit instruction state
// R3 - four regions: low, sram, flash, registers
// R4 - register window is 4 KB near top
// R5 - unmapped access answers with data abort
// R6 - little endian byte order
// R7 - sram at 0x40000, 1024 or 1536 words
// R8 - sram byte, halfword and word access
// R9 - low region 30 or 94 KB mirror
// R10 - flash at address zero after reset
// R11 - remap bit 0 selects sram at zero
// R12 - every reset clears the remap bit
// R13 - software writes zero to remap bits 7:1
// R14 - kernel runs first, then reset vector
// R15 - cause bits: power, watchdog, software, pin
// R16 - clear register clears bits written one
// R17 - writing cause bit 2 makes software reset
// R18 - cause bits 7:4 read zero
// R19 - pending soft bit not cleared retriggers reset
// R20 - sram intact after power-on only if flagged
// R21 - remap issued from absolute flash address
// R22 - resets hit all but cause; watchdog power-only
module bsc_sysctl import bsc_pkg::*; #(
    parameter int SRAM_WORDS = 1024,
    parameter int REMAP_KB = 30
) (
    // clock and power-on reset
    input wire logic mclk,
    input wire logic sys_rst,
    // core bus
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic [1:0] bus_size,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    output logic bus_ack,
    output logic bus_abort,
    output logic [31:0] bus_rdata,
    // flash array
    output logic flash_rd,
    output logic flash_wr,
    output logic [31:0] flash_addr,
    output logic [31:0] flash_wdata,
    output logic [1:0] flash_size,
    input wire logic [31:0] flash_rdata,
    // peripheral registers
    output logic mmr_rd,
    output logic mmr_wr,
    output logic [11:0] mmr_addr,
    output logic [31:0] mmr_wdata,
    output logic [1:0] mmr_size,
    input wire logic [31:0] mmr_rdata,
    // reset sources and results
    input wire logic ext_rst_n_pin,
    input wire logic wdt_timeout,
    input wire logic kernel_done,
    input wire logic low_voltage_flag_en,
    input wire logic low_voltage_flag,
    output logic chip_rst,
    output logic wdt_rst,
    output logic kernel_active,
    output logic sram_intact,
    output logic remap_sram,
    // interrupt entry
    input wire logic fast_interrupt_pin,
    input wire logic normal_interrupt_pin,
    output logic exc_enter,
    output logic [4:0] exc_vector,
    output logic exc_wide_state
);
    localparam int SAW = $clog2(SRAM_WORDS);
    localparam logic [31:0] SRAM_BYTES = 32'(SRAM_WORDS * 4);
    localparam logic [31:0] REMAP_BYTES = 32'(REMAP_KB * 1024);
    localparam logic [31:0] SRAM_END = 32'(SRAM_BASE + SRAM_BYTES);
    localparam logic [31:0] FLASH_END = 32'(FLASH_BASE + REMAP_BYTES);

    if (!(SRAM_WORDS == 1024 || SRAM_WORDS == 1536) || !(REMAP_KB == 30 || REMAP_KB == 94))
    begin : g_bad_variant
        $error("bsc_sysctl: unsupported memory variant");
    end

    typedef struct packed {
        logic busy;
        logic wr;
        logic [1:0] size;
        bsc_region_t region;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic ack;
        logic abort;
        logic [31:0] rdata;
        logic flash_rd;
        logic flash_wr;
        logic mmr_rd;
        logic mmr_wr;
        logic remap;
        logic [3:0] cause;
        logic soft_req;
        bsc_rstate_t rstate;
        logic [7:0] hold_cnt;
        logic chip_rst;
        logic wdt_rst;
        logic por_pend;
        logic kernel_active;
        logic sram_intact;
        logic [1:0] ext_sync;
        logic [IRQ_STAGES-1:0] fiq_sh;
        logic [IRQ_STAGES-1:0] irq_sh;
        logic exc_enter;
        logic [4:0] exc_vector;
        logic exc_wide;
    } bsc_state_t;

    bsc_state_t st;
    bsc_state_t next_st;
    bsc_region_t dec;
    logic [31:0] dec_off;
    logic [31:0] wlane;
    logic [3:0] sram_be;
    logic [31:0] sram_rdata;
    logic [31:0] raw;
    logic [31:0] shifted;
    logic [3:0] cause_set;
    logic [3:0] cause_clr;
    logic take;
    logic ext_low;
    logic fast_edge;
    logic norm_edge;

    // region decode of the incoming address
    always_comb begin
        dec = RG_NONE;
        dec_off = 32'h0;
        if (bus_addr < REMAP_BYTES) begin // [R9]
            if (st.remap) begin // [R11]
                if (bus_addr < SRAM_BYTES) begin
                    dec = RG_SRAM;
                    dec_off = bus_addr;
                end
            end else begin // [R10]
                dec = RG_FLASH;
                dec_off = bus_addr;
            end
        end else if (bus_addr >= SRAM_BASE && bus_addr < SRAM_END) begin // [R7]
            dec = RG_SRAM;
            dec_off = bus_addr - SRAM_BASE;
        end else if (bus_addr >= FLASH_BASE && bus_addr < FLASH_END) begin // [R3]
            dec = RG_FLASH;
            dec_off = bus_addr - FLASH_BASE;
        end else if (bus_addr[31:12] == MMR_BASE[31:12]) begin // [R4]
            dec_off = {20'h0, bus_addr[11:0]};
            if (bus_addr[31:2] == ZERO_SEL_ADDR[31:2] || bus_addr[31:2] == CAUSE_STAT_ADDR[31:2]
                || bus_addr[31:2] == CAUSE_CLR_ADDR[31:2]) begin
                dec = RG_SYS;
            end else begin
                dec = RG_MMR;
            end
        end
    end

    // write data replicated into every lane the access may hit
    always_comb begin
        unique case (bus_size)
            SZ_BYTE: wlane = {4{bus_wdata[7:0]}};
            SZ_HALF: wlane = {2{bus_wdata[15:0]}};
            default: wlane = bus_wdata;
        endcase
    end

    always_comb begin
        unique case (st.size)
            SZ_BYTE: sram_be = 4'h1 << st.addr[1:0]; // [R8]
            SZ_HALF: sram_be = 4'h3 << {st.addr[1], 1'b0}; // [R8]
            default: sram_be = 4'hF;
        endcase
    end

    bsc_sram #(
        .WORDS(SRAM_WORDS)
    ) u_sram (
        .mclk(mclk),
        .en(st.busy && st.region == RG_SRAM),
        .wr(st.wr),
        .be(sram_be),
        .idx(st.addr[SAW+1:2]),
        .wdata(st.wdata),
        .rdata(sram_rdata)
    );

    always_comb begin
        unique case (st.region)
            RG_SRAM: raw = sram_rdata;
            RG_FLASH: raw = flash_rdata;
            RG_MMR: raw = mmr_rdata;
            RG_SYS: begin
                if (st.addr[11:2] == ZERO_SEL_ADDR[11:2]) begin
                    raw = {31'h0, st.remap};
                end else if (st.addr[11:2] == CAUSE_STAT_ADDR[11:2]) begin
                    raw = {28'h0, st.cause}; // [R18]
                end else begin
                    raw = 32'h0;
                end
            end
            default: raw = 32'h0;
        endcase
        shifted = raw >> {st.addr[1:0], 3'h0}; // [R6]
    end

    // a request still held in its ack cycle is the old one: taking it again would repeat writes
    assign take = bus_req && !st.busy && !st.ack && st.rstate != RS_HOLD;
    assign ext_low = !st.ext_sync[1];
    assign fast_edge = st.fiq_sh[IRQ_STAGES-2] && !st.fiq_sh[IRQ_STAGES-1];
    assign norm_edge = st.irq_sh[IRQ_STAGES-2] && !st.irq_sh[IRQ_STAGES-1];

    always_comb begin
        next_st = st;
        cause_set = 4'h0;
        cause_clr = 4'h0;
        next_st.ack = 1'b0;
        next_st.abort = 1'b0;
        next_st.flash_rd = 1'b0;
        next_st.flash_wr = 1'b0;
        next_st.mmr_rd = 1'b0;
        next_st.mmr_wr = 1'b0;
        next_st.wdt_rst = 1'b0;
        // first two stages of each shift are the pin synchronisers
        next_st.ext_sync = {st.ext_sync[0], ext_rst_n_pin};
        next_st.fiq_sh = {st.fiq_sh[IRQ_STAGES-2:0], fast_interrupt_pin}; // [R1]
        next_st.irq_sh = {st.irq_sh[IRQ_STAGES-2:0], normal_interrupt_pin}; // [R1]
        next_st.exc_enter = fast_edge || norm_edge; // [R1]
        next_st.exc_wide = fast_edge || norm_edge ? 1'b1 : st.exc_wide; // [R2]
        if (fast_edge) begin
            next_st.exc_vector = VEC_FAST;
        end else if (norm_edge) begin
            next_st.exc_vector = VEC_NORM;
        end
        if (take) begin
            next_st.busy = 1'b1;
            next_st.wr = bus_write;
            next_st.size = bus_size;
            next_st.region = dec;
            next_st.addr = dec_off;
            next_st.wdata = wlane;
            next_st.flash_rd = dec == RG_FLASH && !bus_write;
            next_st.flash_wr = dec == RG_FLASH && bus_write;
            next_st.mmr_rd = dec == RG_MMR && !bus_write;
            next_st.mmr_wr = dec == RG_MMR && bus_write;
        end else if (st.busy) begin
            next_st.busy = 1'b0;
            next_st.ack = 1'b1;
            next_st.abort = st.region == RG_NONE; // [R5]
            unique case (st.size)
                SZ_BYTE: next_st.rdata = {24'h0, shifted[7:0]};
                SZ_HALF: next_st.rdata = {16'h0, shifted[15:0]};
                default: next_st.rdata = shifted;
            endcase
            if (st.wr || st.region == RG_NONE) begin
                next_st.rdata = 32'h0;
            end
            if (st.wr && st.region == RG_SYS) begin
                if (st.addr[11:2] == ZERO_SEL_ADDR[11:2]) begin
                    next_st.remap = st.wdata[REMAP_BIT]; // [R11]
                end else if (st.addr[11:2] == CAUSE_STAT_ADDR[11:2]) begin
                    next_st.soft_req = st.wdata[CAUSE_SOFT]; // [R17]
                end else begin
                    cause_clr = st.wdata[3:0]; // [R16]
                    next_st.soft_req = st.cause[CAUSE_SOFT] && !st.wdata[CAUSE_SOFT]; // [R19]
                end
            end
        end
        // reset sequencing: hold, then kernel, then user code from vector zero
        if (st.rstate != RS_HOLD && (wdt_timeout || ext_low || st.soft_req)) begin
            cause_set[CAUSE_WDT] = wdt_timeout; // [R15]
            cause_set[CAUSE_SOFT] = st.soft_req; // [R15]
            cause_set[CAUSE_PIN] = ext_low; // [R15]
            next_st.rstate = RS_HOLD;
            next_st.hold_cnt = RESET_HOLD_CYC;
            next_st.chip_rst = 1'b1; // [R22]
            next_st.remap = REMAP_RST; // [R12]
            next_st.soft_req = 1'b0;
            next_st.busy = 1'b0;
            next_st.ack = 1'b0;
            next_st.abort = 1'b0;
            next_st.flash_rd = 1'b0;
            next_st.flash_wr = 1'b0;
            next_st.mmr_rd = 1'b0;
            next_st.mmr_wr = 1'b0;
            next_st.kernel_active = 1'b1;
            next_st.sram_intact = 1'b0;
        end else if (st.rstate == RS_HOLD) begin
            if (ext_low) begin
                next_st.hold_cnt = RESET_HOLD_CYC;
            end else if (st.hold_cnt != 8'h0) begin
                next_st.hold_cnt = st.hold_cnt - 8'h1;
            end else begin
                next_st.rstate = RS_KERNEL; // [R14]
                next_st.chip_rst = 1'b0;
                next_st.por_pend = 1'b0;
                // only a power-on can corrupt sram; the flag tells if it did not
                next_st.sram_intact = st.por_pend ? low_voltage_flag_en && low_voltage_flag : 1'b1; // [R20]
            end
        end else if (st.rstate == RS_KERNEL && kernel_done) begin
            next_st.rstate = RS_RUN; // [R14]
            next_st.kernel_active = 1'b0;
        end
        // a reset event in the same cycle as a clear keeps its bit
        next_st.cause = (st.cause & ~cause_clr) | cause_set; // [R16]
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
            st.region <= RG_NONE;
            st.remap <= REMAP_RST; // [R12]
            st.cause <= CAUSE_RST; // [R15]
            st.rstate <= RS_HOLD;
            st.hold_cnt <= RESET_HOLD_CYC;
            st.chip_rst <= 1'b1;
            st.wdt_rst <= 1'b1; // [R22]
            st.por_pend <= 1'b1;
            st.kernel_active <= 1'b1;
            st.ext_sync <= 2'h3;
            st.exc_vector <= VEC_NORM;
        end else begin
            st <= next_st;
        end
    end

    assign bus_ack = st.ack;
    assign bus_abort = st.abort;
    assign bus_rdata = st.rdata;
    assign flash_rd = st.flash_rd;
    assign flash_wr = st.flash_wr;
    assign flash_addr = st.addr;
    assign flash_wdata = st.wdata;
    assign flash_size = st.size;
    assign mmr_rd = st.mmr_rd;
    assign mmr_wr = st.mmr_wr;
    assign mmr_addr = st.addr[11:0];
    assign mmr_wdata = st.wdata;
    assign mmr_size = st.size;
    assign chip_rst = st.chip_rst;
    assign wdt_rst = st.wdt_rst;
    assign kernel_active = st.kernel_active;
    assign sram_intact = st.sram_intact;
    assign remap_sram = st.remap;
    assign exc_enter = st.exc_enter;
    assign exc_vector = st.exc_vector;
    assign exc_wide_state = st.exc_wide;

    irq_latency_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R1]
        exc_enter |-> $past(st.fiq_sh[1] || st.irq_sh[1], 3))
        else $error("exception entry sooner than five cycles");
    wide_entry_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
        exc_enter |-> exc_wide_state && (exc_vector == VEC_FAST || exc_vector == VEC_NORM))
        else $error("exception entry not in wide state");
    unmapped_abort_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R5]
        take && dec == RG_NONE && !(wdt_timeout || ext_low || st.soft_req)
        |=> !bus_ack ##1 bus_ack && bus_abort)
        else $error("unmapped access did not abort");
    mmr_window_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R4]
        take && bus_addr[31:12] == MMR_BASE[31:12] |-> dec == RG_MMR || dec == RG_SYS)
        else $error("register window not decoded");
    flash_low_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R10]
        take && !st.remap && !bus_write && bus_addr < VECTOR_TOP
        && !(wdt_timeout || ext_low || st.soft_req) |=> flash_rd && flash_addr == $past(bus_addr))
        else $error("vectors not fetched from flash");
    remap_reset_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R12]
        chip_rst |-> !remap_sram)
        else $error("remap survived a reset");
    soft_reset_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R17]
        take && bus_write && bus_addr == CAUSE_STAT_ADDR && bus_wdata[CAUSE_SOFT]
        && st.rstate == RS_RUN |-> ##[2:3] chip_rst)
        else $error("software reset not generated");
    clear_retrig_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R19]
        take && bus_write && bus_addr == CAUSE_CLR_ADDR && st.cause[CAUSE_SOFT]
        && !bus_wdata[CAUSE_SOFT] && st.rstate == RS_RUN |-> ##[2:3] chip_rst)
        else $error("clear without soft bit did not retrigger");
    cause_top_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R18]
        take && !bus_write && bus_addr == CAUSE_STAT_ADDR |=> ##1 bus_rdata[31:4] == 28'h0)
        else $error("cause upper bits not zero");
    wdt_por_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R22]
        $rose(chip_rst) |-> !wdt_rst)
        else $error("watchdog reset outside power-on");
endmodule : bsc_sysctl

// ### tb/bsc_far_model.sv
// flash array and peripheral register stand-in for the system control block
`timescale 1ns/1ns
module bsc_far_model (
    // clock
    input wire logic mclk,
    // flash side
    input wire logic flash_rd,
    input wire logic [31:0] flash_addr,
    output logic [31:0] flash_rdata,
    // register side
    input wire logic mmr_rd,
    input wire logic mmr_wr,
    input wire logic [31:0] mmr_wdata,
    output logic [31:0] mmr_rdata
);
    logic [31:0] mmr_word = 32'h0;
    logic [31:0] idle_f = 32'h0;
    logic [31:0] idle_m = 32'h0;
    // outside a read the lines toggle, so a late sample never looks valid
    always_ff @(posedge mclk) begin
        idle_f <= ~flash_rdata;
        idle_m <= ~mmr_rdata;
        if (mmr_wr) begin
            mmr_word <= mmr_wdata;
        end
    end
    // flash word carries its own offset so a wrong mirror shows at once
    assign flash_rdata = flash_rd ? {16'hF1A5, flash_addr[15:0]} : idle_f;
    assign mmr_rdata = mmr_rd ? mmr_word : idle_m;
endmodule : bsc_far_model

// ### tb/tb_bsc_sysctl.sv
// self-checking bench of the system control block
`timescale 1ns/1ns
module tb_bsc_sysctl import bsc_pkg::*;;
    typedef struct {
        logic wr;
        logic [1:0] sz;
        logic [31:0] a;
        logic [31:0] d;
        logic [31:0] q;
        logic ab;
    } bsc_row_t;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic bus_req = 1'b0;
    logic bus_write = 1'b0;
    logic [1:0] bus_size = SZ_WORD;
    logic [31:0] bus_addr = 32'h0;
    logic [31:0] bus_wdata = 32'h0;
    logic ext_rst_n_pin = 1'b1;
    logic wdt_timeout = 1'b0;
    logic kernel_done = 1'b0;
    logic low_voltage_flag_en = 1'b0;
    logic low_voltage_flag = 1'b0;
    logic fast_interrupt_pin = 1'b0;
    logic normal_interrupt_pin = 1'b0;
    logic bus_ack, bus_abort, flash_rd, mmr_rd, mmr_wr, chip_rst, wdt_rst;
    logic kernel_active, sram_intact, remap_sram, exc_enter, exc_wide_state, ab;
    logic [31:0] bus_rdata, flash_addr, flash_rdata, mmr_wdata, mmr_rdata, rd;
    logic [4:0] exc_vector;
    logic flash_wr;
    logic [1:0] flash_size, mmr_size;
    logic [11:0] mmr_addr;
    logic [31:0] flash_wdata;
    int wr_pulses = 0;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    // ordinary accesses with the low region still on flash
    bsc_row_t rows[20] = '{
        '{1'h1, SZ_WORD, 32'h0004_0000, 32'h4433_2211, 32'h0, 1'h0},
        '{1'h0, SZ_BYTE, 32'h0004_0000, 32'h0, 32'h11, 1'h0},
        '{1'h0, SZ_BYTE, 32'h0004_0003, 32'h0, 32'h44, 1'h0},
        '{1'h0, SZ_HALF, 32'h0004_0002, 32'h0, 32'h4433, 1'h0},
        '{1'h1, SZ_BYTE, 32'h0004_0001, 32'hAA, 32'h0, 1'h0},
        '{1'h1, SZ_HALF, 32'h0004_0002, 32'hBEEF, 32'h0, 1'h0},
        '{1'h0, SZ_WORD, 32'h0004_0000, 32'h0, 32'hBEEF_AA11, 1'h0},
        '{1'h1, SZ_WORD, 32'h0004_0FFC, 32'h0123_ABCD, 32'h0, 1'h0},
        '{1'h0, SZ_WORD, 32'h0004_0FFC, 32'h0, 32'h0123_ABCD, 1'h0},
        '{1'h0, SZ_WORD, 32'h0004_1000, 32'h0, 32'h0, 1'h1},
        '{1'h0, SZ_WORD, 32'h0000_0010, 32'h0, 32'hF1A5_0010, 1'h0},
        '{1'h0, SZ_WORD, 32'h0008_0010, 32'h0, 32'hF1A5_0010, 1'h0},
        '{1'h0, SZ_WORD, 32'h0000_77FC, 32'h0, 32'hF1A5_77FC, 1'h0},
        '{1'h0, SZ_WORD, 32'h0000_7800, 32'h0, 32'h0, 1'h1},
        '{1'h0, SZ_WORD, 32'h1000_0000, 32'h0, 32'h0, 1'h1},
        '{1'h0, SZ_WORD, 32'hFFFE_FFFC, 32'h0, 32'h0, 1'h1},
        '{1'h1, SZ_WORD, 32'hFFFF_0E08, 32'h5A, 32'h0, 1'h0},
        '{1'h0, SZ_WORD, 32'hFFFF_0E08, 32'h0, 32'h5A, 1'h0},
        '{1'h0, SZ_WORD, ZERO_SEL_ADDR, 32'h0, 32'h0, 1'h0},
        '{1'h0, SZ_WORD, CAUSE_CLR_ADDR, 32'h0, 32'h0, 1'h0}
    };

    bsc_sysctl dut_u (
        .mclk, .sys_rst, .bus_req, .bus_write, .bus_size, .bus_addr, .bus_wdata,
        .bus_ack, .bus_abort, .bus_rdata, .flash_rd, .flash_wr, .flash_addr,
        .flash_wdata, .flash_size, .flash_rdata, .mmr_rd, .mmr_wr, .mmr_addr,
        .mmr_wdata, .mmr_size, .mmr_rdata, .ext_rst_n_pin, .wdt_timeout,
        .kernel_done, .low_voltage_flag_en, .low_voltage_flag, .chip_rst, .wdt_rst,
        .kernel_active, .sram_intact, .remap_sram, .fast_interrupt_pin,
        .normal_interrupt_pin, .exc_enter, .exc_vector, .exc_wide_state
    );
    bsc_far_model far_u (
        .mclk, .flash_rd, .flash_addr, .flash_rdata, .mmr_rd, .mmr_wr, .mmr_wdata,
        .mmr_rdata
    );

    initial begin
        forever #5 mclk = ~mclk;
    end

    task automatic finish_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // request held until ack is sampled, then released with idle edges after
    task automatic xfer(input logic wr, input logic [1:0] sz, input logic [31:0] a,
                        input logic [31:0] d);
        @(posedge mclk);
        bus_req <= 1'b1;
        bus_write <= wr;
        bus_size <= sz;
        bus_addr <= a;
        bus_wdata <= d;
        for (n = 0; n < 20 && bus_ack !== 1'b1; n++) @(posedge mclk);
        rd = bus_rdata;
        ab = bus_abort;
        bus_req <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : xfer

    // wait through the reset hold, finish the kernel, then read the cause
    task automatic boot(input logic [3:0] cause);
        for (n = 0; n < 60 && chip_rst !== 1'b1; n++) @(posedge mclk);
        for (n = 0; n < 90 && chip_rst !== 1'b0; n++) @(posedge mclk);
        check("no_hold_left", {31'h0, chip_rst}, 32'h0);
        check("remap_clear", {31'h0, remap_sram}, 32'h0);
        check("kernel_first", {31'h0, kernel_active}, 32'h1);
        kernel_done <= 1'b1;
        @(posedge mclk);
        kernel_done <= 1'b0;
        repeat (2) @(posedge mclk);
        check("kernel_end", {31'h0, kernel_active}, 32'h0);
        xfer(1'h0, SZ_WORD, CAUSE_STAT_ADDR, 32'h0);
        check("cause", rd, {28'h0, cause});
    endtask : boot

    always @(posedge mclk) begin
        cycles++;
        if (flash_wr === 1'b1) begin
            wr_pulses++;
        end
        if (cycles == 20000) begin
            miscompares++;
            $display("run cut short after %0d cycles", cycles);
            finish_test();
        end
    end

    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        boot(4'h1);
        check("intact_por", {31'h0, sram_intact}, 32'h0);
        foreach (rows[i]) begin
            xfer(rows[i].wr, rows[i].sz, rows[i].a, rows[i].d);
            check("rdata", rd, rows[i].q);
            check("abort", {31'h0, ab}, {31'h0, rows[i].ab});
        end
        xfer(1'h1, SZ_BYTE, 32'hFFFF_0E09, 32'h77);
        check("mmr_addr", {20'h0, mmr_addr}, 32'hE09);
        check("mmr_size", {30'h0, mmr_size}, {30'h0, SZ_BYTE});
        check("mmr_wdata", mmr_wdata, 32'h7777_7777);
        xfer(1'h1, SZ_HALF, 32'h0008_0012, 32'h1234);
        check("flash_wr", 32'(wr_pulses), 32'h1);
        check("flash_addr", flash_addr, 32'h12);
        check("flash_size", {30'h0, flash_size}, {30'h0, SZ_HALF});
        check("flash_wdata", flash_wdata, 32'h1234_1234);
        $display("test table done");
        xfer(1'h1, SZ_WORD, ZERO_SEL_ADDR, 32'h1);
        check("remap_set", {31'h0, remap_sram}, 32'h1);
        xfer(1'h0, SZ_WORD, 32'h0, 32'h0);
        check("sram_low", rd, 32'hBEEF_AA11);
        xfer(1'h0, SZ_WORD, 32'h1000, 32'h0);
        check("sram_low_end", {31'h0, ab}, 32'h1);
        xfer(1'h1, SZ_WORD, ZERO_SEL_ADDR, 32'h0);
        xfer(1'h0, SZ_WORD, 32'h0, 32'h0);
        check("flash_back", rd, 32'hF1A5_0000);
        // leave sram mapped so the soft reset has to undo it
        xfer(1'h1, SZ_WORD, ZERO_SEL_ADDR, 32'h1);
        $display("test remap done");
        xfer(1'h1, SZ_BYTE, CAUSE_STAT_ADDR, 32'h4);
        check("wdt_kept", {31'h0, wdt_rst}, 32'h0);
        boot(4'h5);
        check("intact_soft", {31'h0, sram_intact}, 32'h1);
        xfer(1'h0, SZ_WORD, 32'h0004_0000, 32'h0);
        check("sram_kept", rd, 32'hBEEF_AA11);
        // clearing only the power bit leaves the soft bit, which retriggers
        xfer(1'h1, SZ_WORD, CAUSE_CLR_ADDR, 32'h1);
        boot(4'h4);
        xfer(1'h1, SZ_WORD, CAUSE_CLR_ADDR, 32'h4);
        xfer(1'h0, SZ_WORD, CAUSE_STAT_ADDR, 32'h0);
        check("cause_cleared", rd, 32'h0);
        check("no_soft", {31'h0, chip_rst}, 32'h0);
        $display("test soft reset done");
        @(posedge mclk);
        wdt_timeout <= 1'b1;
        @(posedge mclk);
        wdt_timeout <= 1'b0;
        boot(4'h2);
        ext_rst_n_pin <= 1'b0;
        repeat (4) @(posedge mclk);
        ext_rst_n_pin <= 1'b1;
        boot(4'hA);
        xfer(1'h1, SZ_WORD, CAUSE_STAT_ADDR, 32'hF0);
        xfer(1'h0, SZ_WORD, CAUSE_STAT_ADDR, 32'h0);
        check("cause_upper", rd, 32'hA);
        $display("test reset kinds done");
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            fast_interrupt_pin <= (k == 0);
            normal_interrupt_pin <= (k == 1);
            for (n = 0; n < 20 && exc_enter !== 1'b1; n++) @(posedge mclk);
            check("irq_latency", 32'(n), 32'(IRQ_STAGES + 1));
            check("vector", {27'h0, exc_vector}, {27'h0, k == 0 ? VEC_FAST : VEC_NORM});
            check("wide_state", {31'h0, exc_wide_state}, 32'h1);
            @(posedge mclk);
            check("one_entry", {31'h0, exc_enter}, 32'h0);
            repeat (8) @(posedge mclk);
            fast_interrupt_pin <= 1'b0;
            normal_interrupt_pin <= 1'b0;
            repeat (3) @(posedge mclk);
        end
        $display("test interrupts done");
        low_voltage_flag_en <= 1'b1;
        low_voltage_flag <= 1'b1;
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        check("wdt_por", {31'h0, wdt_rst}, 32'h1);
        sys_rst <= 1'b0;
        boot(4'h1);
        check("intact_flag", {31'h0, sram_intact}, 32'h1);
        $display("test power-on done");
        finish_test();
    end
endmodule : tb_bsc_sysctl
